// [logic/tc_dual_timer.sv]
// Two timer/counters with shared count/toggle pins and overflow flags.
// Assumes control inputs are synchronous to i_clk; pins are asynchronous.
//
// Functional notes
// - Timer mode adds one every machine cycle
// - Counter mode adds one per pin fall
// - Count pin sampled once per machine cycle
// - Modes 0,1,2,3,6; mode 3 differs
// - Mode 0: 8-bit count, divide-by-32 prescaler
// - Mode 1: full 16-bit count
// - Mode 2: 8-bit count with auto-reload
// - Timer 1 mode 3 halts and holds
// - Timer 0 mode 3 splits into two
// - Timer 1 overflow still feeds baud tick
// - Mode 6 PWM, 256-clock period
// - Overflow toggles the shared count pin
// - Toggle output high before first overflow
`default_nettype none

module tc_dual_timer (
  input  wire logic                         i_clk,
  input  wire logic                         i_reset_n,
  input  wire tc_pkg::tc_ctrl_t  [1:0]      i_ctrl,
  input  wire logic              [1:0]      i_load,
  input  wire tc_pkg::tc_count_t [1:0]      i_load_val,
  input  wire logic              [1:0]      i_flag_clr,
  input  wire logic                         i_first_count_toggle_pin,
  input  wire logic                         i_second_count_toggle_pin,
  output logic                              o_first_count_toggle_pin,
  output logic                              o_first_count_toggle_pin_oe_n,
  output logic                              o_second_count_toggle_pin,
  output logic                              o_second_count_toggle_pin_oe_n,
  output tc_pkg::tc_count_t      [1:0]      o_count,
  output logic                   [1:0]      o_ovf_flag,
  output logic                   [1:0]      o_irq,
  output logic                              o_baud_tick
);
  import tc_pkg::*;

  logic              rst_meta_q;
  logic              rst_n_q;
  logic      [1:0]   pin_in;
  logic      [1:0]   fall;
  logic      [1:0]   pin_out;
  logic      [1:0]   pin_oe_n;
  tc_count_t [1:0]   cnt_q;
  tc_count_t [1:0]   cnt_d;
  logic      [1:0]   inc;
  logic      [1:0]   ovf_main;
  logic              ovf_split_hi;
  logic      [1:0]   flag_set;
  logic      [1:0]   pwm_en;
  logic      [1:0]   pwm_lvl;
  logic      [15:0]  cat [2];
  logic              t0_split;

  // Reset release through two flops; assertion is asynchronous
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  assign pin_in   = {i_second_count_toggle_pin, i_first_count_toggle_pin};
  assign t0_split = (i_ctrl[0].mode == TC_MODE_SPLIT);

  default clocking @(posedge i_clk); endclocking
  default disable iff (!rst_n_q);

  genvar gi;
  generate
    for (gi = 0; gi < TC_NTMR; gi++) begin : g_tmr
      logic [12:0] c13;
      logic [15:0] c16;
      logic [7:0]  tl1;
      logic [7:0]  th1;
      logic        split_hi_inc;

      tc_pin_sync u_sync (
        .i_clk   (i_clk),
        .i_rst_n (rst_n_q),
        .i_pin   (pin_in[gi]),
        .o_fall  (fall[gi])
      );

      // Incremented copies of the count in each width
      assign c13 = {cnt_q[gi].th, cnt_q[gi].tl[TC_PRESC_BITS-1:0]} + 13'h0001;
      assign c16 = {cnt_q[gi].th, cnt_q[gi].tl} + 16'h0001;
      assign tl1 = cnt_q[gi].tl + 8'h01;
      assign th1 = cnt_q[gi].th + 8'h01;
      assign cat[gi] = {cnt_q[gi].th, cnt_q[gi].tl};

      assign inc[gi] = i_ctrl[gi].run & (i_ctrl[gi].cnt_sel ? fall[gi] : 1'b1);

      // Upper byte of split timer 0 counts cycles under timer 1's run bit
      if (gi == 0) begin : g_hi
        assign split_hi_inc = t0_split & i_ctrl[1].run;
      end else begin : g_nohi
        assign split_hi_inc = 1'b0;
      end

      always_comb begin
        cnt_d[gi]    = cnt_q[gi];
        ovf_main[gi] = 1'b0;
        pwm_en[gi]   = 1'b0;
        pwm_lvl[gi]  = 1'b0;
        case (i_ctrl[gi].mode)
          TC_MODE_13: begin
            if (inc[gi]) begin
              {cnt_d[gi].th, cnt_d[gi].tl[TC_PRESC_BITS-1:0]} = c13;
              ovf_main[gi] = (c13 == 13'h0000);
            end
          end
          TC_MODE_16: begin
            if (inc[gi]) begin
              cnt_d[gi]    = c16;
              ovf_main[gi] = (c16 == 16'h0000);
            end
          end
          TC_MODE_RLD: begin
            if (inc[gi]) begin
              cnt_d[gi].tl = (tl1 == 8'h00) ? cnt_q[gi].th : tl1;
              ovf_main[gi] = (tl1 == 8'h00);
            end
          end
          TC_MODE_SPLIT: begin
            if (gi == 0) begin
              if (inc[gi]) begin
                cnt_d[gi].tl = tl1;
                ovf_main[gi] = (tl1 == 8'h00);
              end
              if (split_hi_inc) begin
                cnt_d[gi].th = th1;
              end
            end
          end
          // PWM over 256 clocks
          // Low byte wraps freely; high byte is the compare level
          TC_MODE_PWM: begin
            pwm_en[gi]  = 1'b1;
            pwm_lvl[gi] = (cnt_q[gi].tl < cnt_q[gi].th);
            if (inc[gi]) begin
              cnt_d[gi].tl = tl1;
              ovf_main[gi] = (tl1 == 8'h00);
            end
          end
          // Unused codes hold the count
          default: begin
            cnt_d[gi] = cnt_q[gi];
          end
        endcase
      end

      // Count register; a load takes priority over counting
      always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          cnt_q[gi] <= TC_COUNT_RST;
        end else if (i_load[gi]) begin
          cnt_q[gi] <= i_load_val[gi];
        end else begin
          cnt_q[gi] <= cnt_d[gi];
        end
      end

      // Sticky overflow flag
      // Set wins over a clear in the same cycle, so no overflow is lost
      always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          o_ovf_flag[gi] <= 1'b0;
          o_irq[gi]      <= 1'b0;
        end else begin
          o_ovf_flag[gi] <= (o_ovf_flag[gi] & ~i_flag_clr[gi]) | flag_set[gi];
          o_irq[gi]      <= ((o_ovf_flag[gi] & ~i_flag_clr[gi]) | flag_set[gi]) & i_ctrl[gi].irq_en;
        end
      end

      tc_toggle_out u_tgl (
        .i_clk      (i_clk),
        .i_rst_n    (rst_n_q),
        .i_tgl_en   (i_ctrl[gi].tgl_en),
        .i_ovf      (ovf_main[gi] & ~i_load[gi]),
        .i_pwm_en   (pwm_en[gi]),
        .i_pwm_lvl  (pwm_lvl[gi]),
        .o_pin      (pin_out[gi]),
        .o_pin_oe_n (pin_oe_n[gi])
      );

      timer_step_a: assert property (
        (i_ctrl[gi].run && !i_ctrl[gi].cnt_sel && i_ctrl[gi].mode == TC_MODE_16 && !i_load[gi])
        |=> (cat[gi] == $past(cat[gi]) + 16'h0001))
        else $error("timer did not add one per cycle");

      counter_hold_a: assert property (
        (i_ctrl[gi].cnt_sel && !fall[gi] && i_ctrl[gi].mode == TC_MODE_16 && !i_load[gi])
        |=> $stable(cat[gi]))
        else $error("counter moved without a pin fall");

      counter_step_a: assert property (
        (i_ctrl[gi].run && i_ctrl[gi].cnt_sel && fall[gi] && i_ctrl[gi].mode == TC_MODE_16 && !i_load[gi])
        |=> (cat[gi] == $past(cat[gi]) + 16'h0001))
        else $error("counter did not add one on a pin fall");

      mode13_wrap_a: assert property (
        (i_ctrl[gi].mode == TC_MODE_13 && ovf_main[gi] && !i_load[gi])
        |=> ({cnt_q[gi].th, cnt_q[gi].tl[4:0]} == 13'h0000))
        else $error("13-bit count did not wrap to zero");

      reload_val_a: assert property (
        (i_ctrl[gi].mode == TC_MODE_RLD && ovf_main[gi] && !i_load[gi])
        |=> (cnt_q[gi].tl == $past(cnt_q[gi].th) && $stable(cnt_q[gi].th)))
        else $error("low byte not reloaded from high byte");

      pwm_period_a: assert property (
        (i_ctrl[gi].mode == TC_MODE_PWM && inc[gi] && cnt_q[gi].tl == 8'hff) |-> ovf_main[gi])
        else $error("PWM period did not close after 256 clocks");

      flag_set_a: assert property (
        flag_set[gi] |=> o_ovf_flag[gi])
        else $error("overflow did not set the flag");

      // Clear without a new overflow must drop the flag
      flag_clr_a: assert property (
        (i_flag_clr[gi] && !flag_set[gi]) |=> !o_ovf_flag[gi])
        else $error("flag survived a clear without overflow");

      // Interrupt request mirrors the flag while enabled
      irq_follow_a: assert property (
        i_ctrl[gi].irq_en |=> (o_irq[gi] == o_ovf_flag[gi]))
        else $error("interrupt request does not follow the flag");

      // High byte only moves when the prescaler wraps
      presc_hold_a: assert property (
        (i_ctrl[gi].mode == TC_MODE_13 && cnt_q[gi].tl[4:0] != 5'h1f && !i_load[gi]) |=> $stable(cnt_q[gi].th))
        else $error("13-bit high byte moved before prescaler wrap");

      // Unused low-byte bits stay put in the 13-bit mode
      mode13_keep_a: assert property (
        (i_ctrl[gi].mode == TC_MODE_13 && !i_load[gi]) |=> $stable(cnt_q[gi].tl[7:5]))
        else $error("13-bit mode changed unused low bits");

      // PWM mode must actually enable the pin driver
      pwm_drive_a: assert property (
        pwm_en[gi] |=> !pin_oe_n[gi])
        else $error("PWM mode not driving the pin");

      if (gi == 1) begin : g_halt
        t1_halt_a: assert property (
          (i_ctrl[1].mode == TC_MODE_SPLIT && !i_load[1]) |=> $stable(cat[1]))
          else $error("timer 1 moved in mode 3");
      end
    end
  endgenerate

  // Upper half of split timer 0 wraps from ff while timer 1's run bit is set
  // Kept outside the loop so only one process drives it
  assign ovf_split_hi = t0_split & i_ctrl[1].run & (cnt_q[0].th == 8'hff);

  // Split flags
  // In split mode the upper half of timer 0 owns timer 1's flag
  assign flag_set[0] = ovf_main[0] & ~i_load[0];
  assign flag_set[1] = t0_split ? (ovf_split_hi & ~i_load[0]) : (ovf_main[1] & ~i_load[1]);

  // Timer 1 baud tick
  // Taken from timer 1 itself, so split timer 0 never steals it
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_baud_tick <= 1'b0;
    end else begin
      o_baud_tick <= ovf_main[1] & ~i_load[1];
    end
  end

  // Pin and count outputs, all from flops
  assign o_first_count_toggle_pin       = pin_out[0];
  assign o_first_count_toggle_pin_oe_n  = pin_oe_n[0];
  assign o_second_count_toggle_pin      = pin_out[1];
  assign o_second_count_toggle_pin_oe_n = pin_oe_n[1];
  assign o_count                        = cnt_q;

  split_hi_a: assert property (
    (t0_split && i_ctrl[1].run && !i_load[0] && cnt_q[0].th == 8'hff) |=> (cnt_q[0].th == 8'h00 && o_ovf_flag[1]))
    else $error("split high byte did not wrap and flag");

  baud_tick_a: assert property (
    (ovf_main[1] && !i_load[1]) |=> o_baud_tick)
    else $error("timer 1 overflow missed the baud tick");

  split_c: cover property (t0_split && ovf_main[0] ##[1:300] ovf_split_hi);
  reload_c: cover property (i_ctrl[0].mode == TC_MODE_RLD && ovf_main[0]);
  pwm_c: cover property (pwm_en[1] && ovf_main[1]);

endmodule

`default_nettype wire

// [logic/tc_pin_sync.sv]
// Three-flop synchroniser with falling edge detect for one count pin.
// Assumes an asynchronous pin and the block's synchronised reset.
`default_nettype none

module tc_pin_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_fall
);
  import tc_pkg::*;

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic filt_q;

  // Sync chain; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= TC_PIN_RST;
      s2_q <= TC_PIN_RST;
      s3_q <= TC_PIN_RST;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // One sample per cycle
  // Level accepted only when two stages agree, filters single-cycle glitches
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      filt_q <= TC_PIN_RST;
      o_fall <= 1'b0;
    end else begin
      if (s2_q == s3_q) begin
        filt_q <= s3_q;
      end
      o_fall <= (s2_q == s3_q) & ~s3_q & filt_q;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  single_fall_a: assert property (o_fall |=> !o_fall)
    else $error("fall pulse lasted more than one cycle");

endmodule

`default_nettype wire

// [logic/tc_pkg.sv]
// Shared types and constants of the dual timer/counter block.
// Assumes one 50 MHz clock; one clock edge is one machine cycle.
`default_nettype none

package tc_pkg;

  localparam int          TC_NTMR       = 2;
  localparam int          TC_CLK_HZ     = 50_000_000;

  // Mode codes of each timer
  localparam logic [2:0]  TC_MODE_13    = 3'h0;
  localparam logic [2:0]  TC_MODE_16    = 3'h1;
  localparam logic [2:0]  TC_MODE_RLD   = 3'h2;
  localparam logic [2:0]  TC_MODE_SPLIT = 3'h3;
  localparam logic [2:0]  TC_MODE_PWM   = 3'h6;

  // Mode 0 prescaler width (divide by 32) and PWM period in timer clocks
  localparam int          TC_PRESC_BITS = 5;
  localparam int          TC_PWM_PERIOD = 256;

  // Reset values
  localparam logic [15:0] TC_COUNT_RST  = 16'h0000;
  localparam logic        TC_PIN_RST    = 1'h1;

  // Per-timer control bits
  typedef struct packed {
    logic       run;      // Count enable
    logic       cnt_sel;  // 1: count pin falling edges, 0: machine cycles
    logic [2:0] mode;     // Mode code
    logic       tgl_en;   // Overflow toggle on the count pin
    logic       irq_en;   // Overflow interrupt enable
  } tc_ctrl_t;

  // Count register pair
  typedef struct packed {
    logic [7:0] th;
    logic [7:0] tl;
  } tc_count_t;

endpackage

`default_nettype wire

// [logic/tc_toggle_out.sv]
// Drive side of one shared count/toggle pin: overflow toggle or PWM level.
// Assumes overflow and PWM level come from the same clock domain.
`default_nettype none

module tc_toggle_out (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_tgl_en,
  input  wire logic i_ovf,
  input  wire logic i_pwm_en,
  input  wire logic i_pwm_lvl,
  output logic      o_pin,
  output logic      o_pin_oe_n
);
  import tc_pkg::*;

  // High before first overflow
  // Held high while off, so switching on starts from a high level
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin      <= TC_PIN_RST;
      o_pin_oe_n <= 1'b1;
    end else begin
      o_pin_oe_n <= ~(i_tgl_en | i_pwm_en);
      if (i_pwm_en) begin
        o_pin <= i_pwm_lvl;
      end else if (!i_tgl_en) begin
        o_pin <= TC_PIN_RST;
      end else if (i_ovf) begin
        o_pin <= ~o_pin;
      end
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  toggle_flip_a: assert property (
    (i_tgl_en && !i_pwm_en && $past(i_tgl_en) && i_ovf) |=> (o_pin != $past(o_pin)))
    else $error("pin did not toggle on overflow");

  toggle_start_a: assert property (
    ($rose(i_tgl_en) && !i_pwm_en) |=> o_pin)
    else $error("toggle output not high when enabled");

  toggle_seen_c: cover property (i_tgl_en && !i_pwm_en && i_ovf ##1 !o_pin);

endmodule

`default_nettype wire

// [test/tc_dual_timer_tb.sv]
// Self-checking bench for the dual timer/counter block.
// Assumes the block's package; drives inputs by NBA at rising edges.
`default_nettype none

module tc_dual_timer_tb;
  import tc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk;
  logic            rst_n;
  tc_ctrl_t  [1:0] ctrl;
  logic      [1:0] load;
  tc_count_t [1:0] load_val;
  logic      [1:0] flag_clr;
  logic      [1:0] start;
  logic      [7:0] pulses;
  logic      [1:0] busy;
  logic      [1:0] line;
  logic      [1:0] pin;
  logic      [1:0] oe_n;
  tc_count_t [1:0] count;
  logic      [1:0] flag;
  logic      [1:0] irq;
  logic            baud;
  int              n_errors;
  int              cmp_count;
  int              baud_n = 0;

  tc_dual_timer uut (
    .i_clk                          (clk),
    .i_reset_n                      (rst_n),
    .i_ctrl                         (ctrl),
    .i_load                         (load),
    .i_load_val                     (load_val),
    .i_flag_clr                     (flag_clr),
    .i_first_count_toggle_pin       (line[0]),
    .i_second_count_toggle_pin      (line[1]),
    .o_first_count_toggle_pin       (pin[0]),
    .o_first_count_toggle_pin_oe_n  (oe_n[0]),
    .o_second_count_toggle_pin      (pin[1]),
    .o_second_count_toggle_pin_oe_n (oe_n[1]),
    .o_count                        (count),
    .o_ovf_flag                     (flag),
    .o_irq                          (irq),
    .o_baud_tick                    (baud)
  );

  tc_pin_src src0 (.i_clk(clk), .i_start(start[0]), .i_pulses(pulses), .i_dut_pin(pin[0]),
                   .i_dut_oe_n(oe_n[0]), .o_busy(busy[0]), .o_line(line[0]));
  tc_pin_src src1 (.i_clk(clk), .i_start(start[1]), .i_pulses(pulses), .i_dut_pin(pin[1]),
                   .i_dut_oe_n(oe_n[1]), .o_busy(busy[1]), .o_line(line[1]));

  // Baud pulses counted, so their exact latency does not matter
  always @(posedge clk) begin
    if (baud === 1'b1) begin
      baud_n++;
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic steps(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // New control takes effect at the edge after this one
  task automatic cfg(input int t, input logic run, input logic sel, input logic [2:0] m, input logic tg,
                     input logic ie);
    @(posedge clk);
    ctrl[t] <= '{run: run, cnt_sel: sel, mode: m, tgl_en: tg, irq_en: ie};
  endtask

  task automatic ld(input int t, input logic [15:0] v);
    @(posedge clk);
    load[t]     <= 1'b1;
    load_val[t] <= v;
    @(posedge clk);
    load[t] <= 1'b0;
  endtask

  task automatic clr();
    @(posedge clk);
    flag_clr <= 2'b11;
    @(posedge clk);
    flag_clr <= 2'b00;
  endtask

  // Count after n increments in mode m from v
  function automatic logic [15:0] expect_cnt(input logic [2:0] m, input logic [15:0] v, input int n);
    logic [15:0] r;
    logic [12:0] s;
    r = v;
    for (int k = 0; k < n; k++) begin
      s = {r[15:8], r[4:0]} + 13'h1;
      if (m == TC_MODE_13) r = {s[12:5], r[7:5], s[4:0]};
      else if (m == TC_MODE_16) r = r + 16'h1;
      else r[7:0] = (r[7:0] == 8'hff) ? r[15:8] : r[7:0] + 8'h1;
    end
    return r;
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run is under two thousand cycles
  initial begin
    #200us;
    n_errors++;
    wrap_up();
  end

  initial begin
    logic [15:0] v;
    logic [2:0]  m;
    int          n;
    int          t;
    int          hi;
    static logic [2:0] modes [3] = '{TC_MODE_13, TC_MODE_16, TC_MODE_RLD};
    rst_n = 1'b0;
    ctrl = '0;
    load = '0;
    load_val = '0;
    flag_clr = '0;
    start = '0;
    pulses = '0;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(32'hf791071b));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    steps(3);
    chk("pin idle", 16'({pin, oe_n}), 16'hf);
    // Wrap in mode 1, flags, interrupt and baud tick
    ld(0, 16'hffff);
    ld(1, 16'hffff);
    clr();
    baud_n = 0;
    cfg(0, 1, 0, TC_MODE_16, 0, 1);
    steps(2);
    chk("t0 wrap", count[0], 16'h0001);
    chk("t0 flag irq", 16'({flag[0], irq[0]}), 16'h3);
    cfg(1, 1, 0, TC_MODE_16, 0, 0);
    steps(5);
    chk("t1 flag irq", 16'({flag[1], irq[1]}), 16'h2);
    chk("baud ticks", 16'(baud_n), 16'h1);
    clr();
    steps(1);
    chk("flags cleared", 16'(flag), 16'h0);
    $display("test wrap done");
    // Timer 1 held, timer 0 split
    cfg(1, 0, 0, TC_MODE_SPLIT, 0, 0);
    ld(1, 16'h1234);
    cfg(0, 0, 0, TC_MODE_SPLIT, 0, 0);
    ld(0, 16'hfef0);
    clr();
    cfg(0, 1, 0, TC_MODE_SPLIT, 0, 0);
    cfg(1, 1, 0, TC_MODE_SPLIT, 0, 0);
    steps(3);
    chk("split count", count[0], 16'h01f4);
    chk("split flags", 16'(flag), 16'h2);
    steps(20);
    chk("t1 held", count[1], 16'h1234);
    $display("test mode3 done");
    // Overflow toggle on the shared pin
    cfg(1, 0, 0, TC_MODE_16, 0, 0);
    cfg(0, 0, 0, TC_MODE_16, 0, 0);
    ld(0, 16'hfffd);
    cfg(0, 1, 0, TC_MODE_16, 1, 0);
    steps(2);
    chk("toggle first", 16'({pin[0], oe_n[0]}), 16'h2);
    steps(2);
    chk("toggle low", 16'(pin[0]), 16'h0);
    ld(0, 16'hfffe);
    steps(3);
    chk("toggle high", 16'(pin[0]), 16'h1);
    $display("test toggle done");
    // PWM duty equals compare byte over one 256-clock period
    cfg(0, 0, 0, TC_MODE_PWM, 0, 0);
    ld(0, 16'h4000);
    cfg(0, 1, 0, TC_MODE_PWM, 0, 0);
    steps(4);
    hi = 0;
    repeat (256) begin
      steps(1);
      if (pin[0] === 1'b1) hi++;
    end
    chk("pwm high", 16'(hi), 16'h0040);
    chk("pwm drive", 16'(oe_n[0]), 16'h0);
    $display("test pwm done");
    // Counter mode: falls from the far side, each counted once
    for (t = 0; t < 2; t++) begin
      cfg(t, 0, 1, TC_MODE_16, 0, 0);
      ld(t, 16'h0100);
      cfg(t, 1, 1, TC_MODE_16, 0, 0);
      n = $urandom_range(1, 9);
      @(posedge clk);
      start[t] <= 1'b1;
      pulses   <= 8'(n);
      @(posedge clk);
      start[t] <= 1'b0;
      for (int k = 0; k < 200; k++) begin
        steps(1);
        if (busy[t] === 1'b0) break;
      end
      steps(8);
      chk("event count", count[t], 16'h0100 + 16'(n));
    end
    $display("test counter done");
    // Corner cases first, then random modes, values and spans
    for (int i = 0; i < 22; i++) begin
      t = (i < 2) ? 0 : $urandom_range(0, 1);
      m = (i == 0) ? TC_MODE_13 : (i == 1) ? TC_MODE_RLD : modes[$urandom_range(0, 2)];
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'ha5fe : 16'($urandom);
      n = (i < 2) ? ((i == 0) ? 1 : 3) : $urandom_range(1, 60);
      cfg(t, 0, 0, m, 0, 0);
      ld(t, v);
      cfg(t, 1, 0, m, 0, 0);
      steps(n);
      if (i == 0) chk("mode0 edge", count[t], expect_cnt(m, v, n));
      else if (i == 1) chk("reload edge", count[t], expect_cnt(m, v, n));
      else chk("random count", count[t], expect_cnt(m, v, n));
    end
    $display("test random done");
    wrap_up();
  end
endmodule

`default_nettype wire

// [test/tc_pin_src.sv]
// Far-side event source for one shared count/toggle pin.
// Assumes the bench clock; the wire is resolved here from the block's enable.
`default_nettype none

module tc_pin_src (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic [7:0] i_pulses,
  input  wire logic       i_dut_pin,
  input  wire logic       i_dut_oe_n,
  output logic            o_busy,
  output logic            o_line
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       src = 1'b1;
  logic [7:0] left = 8'h00;
  logic [2:0] ph = 3'h0;

  // Three cycles low, three high: wider than the block's input filter
  always @(posedge i_clk) begin
    if (i_start) begin
      left <= i_pulses;
      ph   <= 3'h0;
    end else if (left != 8'h00) begin
      ph  <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      src <= (ph < 3'h3) ? 1'b0 : 1'b1;
      if (ph == 3'h5) begin
        left <= left - 8'h01;
      end
    end
  end

  assign o_busy = (left != 8'h00);
  assign o_line = i_dut_oe_n ? src : (i_dut_pin & src);
endmodule

`default_nettype wire
